// ### hw/char_clock_gen.sv
/*
  Character clock generator that never emits a phase shorter than HALF
  cycles: a change of wanted level is deferred until the phase is long
  enough, which stretches the clock across a reframe.
  Assumes want_high follows the receive bit counter.
*/
`timescale 1ns/1ps
module char_clock_gen #(
  parameter int HALF = 5
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // wanted level and produced clock
  input  wire logic want_high,
  output logic      char_clk
);
  typedef struct packed {
    logic       lvl;
    logic [3:0] run;
  } clk_st_t;

  clk_st_t st_q;
  clk_st_t st_d;

  assign char_clk = st_q.lvl;

  // change only after a full half phase, else keep stretching
  always_comb begin
    st_d = st_q;
    if (want_high != st_q.lvl && st_q.run >= 4'(HALF - 1)) begin
      st_d.lvl = want_high;
      st_d.run = 4'h0;
    end else if (st_q.run != 4'hf) begin
      st_d.run = st_q.run + 4'h1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ### hw/char_fifo.sv
/*
  Small synchronous FIFO for received characters, flip-flop storage.
  Assumes DEPTH is a power of two and one clock for both sides.
*/
`timescale 1ns/1ps
module char_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_st_t;

  fifo_st_t st_q;
  fifo_st_t st_d;
  logic     push;
  logic     pop;

  // full and empty come from the count, so neither can lie
  assign in_ready  = st_q.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_q.cnt != '0;
  assign out_data  = st_q.mem[st_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_ready && out_valid;

  // next state
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
    if (push && !pop) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end else if (pop && !push) begin
      st_d.cnt = st_q.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// ### hw/link_pkg.sv
/*
  Shared constants of the serial link port and framing control block:
  register offsets, field positions, reset values and character codes.
  Assumes one 40 MHz clock that also acts as the serial bit clock.
*/
// Function
// - with the switch port select low the receiver hears the transmitter loopback, with it high the optical input.
// - a strap chooses whether the switch bit or the connector loopback signal drives the port selection.
// - the connector loopback signal, when strapped in, is driven low for loopback and high for the optical input.
// - while the transmitter is off its outputs sit at positive high and negative low, otherwise they follow the data.
// - a strap chooses whether the switch off bit or the connector link control turns the transmitter off.
// - the link status shows a present signal as high when the detect polarity select is low, as low when it is high.
// - in bypass mode the sync flag marks a sync character on the data bus, at the level of the sync polarity select.
// - in decode mode the sync flag holds active across sync runs and while awaiting the first sync after reframe.
// - with framing enabled every sync character seen in the receive shifter sets the character boundary.
// - with framing disabled the existing character boundary is kept whatever arrives.
// - on reframing the character clock realigns by stretching a phase, never emitting a short pulse.
// - the mode select low gives 8-bit decoded output, high gives the raw 10-bit pattern; the code passes the low eight raw bits, undecoded.
package link_pkg;
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] DATA_OFS = 4'h8;

  // control field positions
  localparam int C_PORT    = 0;
  localparam int C_TXOFF   = 1;
  localparam int C_CDPOL   = 2;
  localparam int C_SYNCPOL = 3;
  localparam int C_FRAME   = 4;
  localparam int C_BYPASS  = 5;
  localparam int C_REFRAME = 6;

  // status field positions
  localparam int S_LINK  = 0;
  localparam int S_SYNC  = 1;
  localparam int S_PORTA = 2;
  localparam int S_TXOFF = 3;
  localparam int S_EMPTY = 4;
  localparam int S_FULL  = 5;
  localparam int S_OVF   = 6;
  localparam int D_VALID = 31;

  // reset values of the control fields
  localparam logic FRAME_RST = 1'b1;
  localparam logic BIT_RST   = 1'b0;

  // ****************************************
  // character timing and codes
  // ****************************************
  localparam logic [3:0] LAST_BIT  = 4'h9;
  localparam logic [3:0] HALF_BITS = 4'h5;
  localparam logic [9:0] K28_RDN   = 10'h0fa;
  localparam logic [9:0] K28_RDP   = 10'h305;
  localparam int CHAR_W     = 10;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;
endpackage

// ### hw/serial_link_ctrl.sv
/*
  Serial link port and framing control: receive port selection,
  transmitter off control, detect and sync polarity, sync framing,
  character clock, receive FIFO and an Avalon-MM register slave.
  Assumes all pins are synchronous to clk and that one serial bit
  passes per clock; straps are static while running.
*/
`timescale 1ns/1ps
module serial_link_ctrl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic             waitrequest,
  output logic [31:0]      readdata,
  // straps, high selects the connector signal
  input  wire logic        strap_port_conn,
  input  wire logic        strap_txoff_conn,
  // connector controls
  input  wire logic        loopback_ctrl,
  input  wire logic        link_control,
  // optical module
  input  wire logic        serial_in_optical,
  input  wire logic        optical_detect,
  // transmitter pins
  output logic             tx_serial_pos,
  output logic             tx_serial_neg,
  // receiver pins
  output logic             link_status,
  output logic             sync_char_flag,
  output logic             recovered_char_clock,
  output logic [9:0]       rx_data
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    link_pkg::bus_state_t bus;
    logic        wreq;
    logic [31:0] rdata;
    logic        port_sw;
    logic        txoff_sw;
    logic        detect_polarity_sel;
    logic        sync_polarity_sel;
    logic        frame_en;
    logic        bypass;
    logic        await;
    logic        ovf;
    logic [9:0]  tx_sr;
    logic [3:0]  tx_cnt;
    logic        tx_rdp;
    logic        tx_p;
    logic        tx_n;
    logic [9:0]  rx_sr;
    logic [3:0]  rx_cnt;
    logic [9:0]  rx_data;
    logic        k28;
    logic        link;
    logic        sync;
  } link_st_t;

  link_st_t   st_q;
  link_st_t   st_d;
  logic       tx_output_off;
  logic       port_a;
  logic       serial_in_loop;
  logic       rx_bit;
  logic [9:0] rx_sr_next;
  logic       k28_hit;
  logic       char_done;
  logic       sig_present;
  logic       sync_active;
  logic       want_high;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [9:0] fifo_out_data;
  logic       fifo_pop;
  logic [9:0] char_word;
  logic       wr_ctrl;
  logic       wr_stat;
  logic       in_ack;

  // registered outputs
  assign waitrequest    = st_q.wreq;
  assign readdata       = st_q.rdata;
  assign tx_serial_pos  = st_q.tx_p;
  assign tx_serial_neg  = st_q.tx_n;
  assign link_status    = st_q.link;
  assign sync_char_flag = st_q.sync;
  assign rx_data        = st_q.rx_data;

  // ****************************************
  // straps and port selection
  // ****************************************
  // straps pick switch or connector; the connector drives low for loopback
  assign port_a         = strap_port_conn ? loopback_ctrl : st_q.port_sw;
  assign tx_output_off  = strap_txoff_conn ? link_control : st_q.txoff_sw;
  assign serial_in_loop = st_q.tx_sr[9];
  assign rx_bit         = port_a ? serial_in_optical : serial_in_loop;

  // ****************************************
  // framing
  // ****************************************
  // a sync in the shifter closes the character at once when framing is on
  assign rx_sr_next = {st_q.rx_sr[8:0], rx_bit};
  assign k28_hit    = rx_sr_next == link_pkg::K28_RDN || rx_sr_next == link_pkg::K28_RDP;
  assign char_done  = st_q.rx_cnt == link_pkg::LAST_BIT || (st_q.frame_en && k28_hit);

  // decode mode keeps the low eight bits, upper bits zero
  assign char_word = st_q.bypass ? rx_sr_next : {2'b00, rx_sr_next[7:0]};

  // loopback has no detect pin, so it counts as always present
  assign sig_present = port_a ? optical_detect : 1'b1;
  assign sync_active = st_q.bypass ? st_q.k28 : (st_q.k28 || st_q.await);

  // first half of a character asks for a high clock
  assign want_high = st_d.rx_cnt < link_pkg::HALF_BITS;

  // ****************************************
  // bus decode
  // ****************************************
  // the access takes effect in the cycle waitrequest is low
  assign in_ack   = st_q.bus == link_pkg::BUS_ACK;
  assign wr_ctrl  = in_ack && write && byteenable[0] && address == link_pkg::CTRL_OFS;
  assign wr_stat  = in_ack && write && byteenable[0] && address == link_pkg::STAT_OFS;
  // pop only a word the answer showed valid, so a push in the wait cycle is not lost
  assign fifo_pop = in_ack && read && address == link_pkg::DATA_OFS && st_q.rdata[link_pkg::D_VALID];

  // next state
  always_comb begin
    st_d = st_q;

    // transmitter sends sync idles, alternating disparity
    st_d.tx_sr  = {st_q.tx_sr[8:0], 1'b0};
    st_d.tx_cnt = st_q.tx_cnt + 4'h1;
    if (st_q.tx_cnt == link_pkg::LAST_BIT) begin
      st_d.tx_cnt = 4'h0;
      st_d.tx_rdp = !st_q.tx_rdp;
      st_d.tx_sr  = st_q.tx_rdp ? link_pkg::K28_RDP : link_pkg::K28_RDN;
    end
    // off forces positive high, negative low
    st_d.tx_p = tx_output_off ? 1'b1 : st_q.tx_sr[9];
    st_d.tx_n = tx_output_off ? 1'b0 : !st_q.tx_sr[9];

    // receive shifter; without framing the count alone keeps the boundary
    st_d.rx_sr  = rx_sr_next;
    st_d.rx_cnt = char_done ? 4'h0 : st_q.rx_cnt + 4'h1;
    if (char_done) begin
      st_d.rx_data = char_word;
      st_d.k28     = k28_hit;
      if (k28_hit) begin
        st_d.await = 1'b0;
      end
      if (!fifo_in_ready) begin
        st_d.ovf = 1'b1;
      end
    end

    // status pins
    st_d.link = sig_present ^ st_q.detect_polarity_sel;
    if (st_q.bypass) begin
      st_d.sync = sync_active ? st_q.sync_polarity_sel : !st_q.sync_polarity_sel;
    end else begin
      st_d.sync = sync_active ? !st_q.sync_polarity_sel : st_q.sync_polarity_sel;
    end

    // control writes; arming reframe wins over a sync in the same cycle
    if (wr_ctrl) begin
      st_d.port_sw  = writedata[link_pkg::C_PORT];
      st_d.txoff_sw = writedata[link_pkg::C_TXOFF];
      st_d.detect_polarity_sel   = writedata[link_pkg::C_CDPOL];
      st_d.sync_polarity_sel = writedata[link_pkg::C_SYNCPOL];
      st_d.frame_en = writedata[link_pkg::C_FRAME];
      st_d.bypass   = writedata[link_pkg::C_BYPASS];
      if (writedata[link_pkg::C_REFRAME]) begin
        st_d.await = 1'b1;
      end
    end
    // overflow clear loses to a new overflow
    if (wr_stat && writedata[link_pkg::S_OVF] && !(char_done && !fifo_in_ready)) begin
      st_d.ovf = 1'b0;
    end

    // bus handshake: one wait cycle, then one answer cycle
    case (st_q.bus)
      link_pkg::BUS_IDLE: begin
        if (read || write) begin
          st_d.bus  = link_pkg::BUS_ACK;
          st_d.wreq = 1'b0;
          if (read) begin
            st_d.rdata = '0;
            case (address)
              link_pkg::CTRL_OFS: begin
                st_d.rdata[link_pkg::C_PORT]    = st_q.port_sw;
                st_d.rdata[link_pkg::C_TXOFF]   = st_q.txoff_sw;
                st_d.rdata[link_pkg::C_CDPOL]   = st_q.detect_polarity_sel;
                st_d.rdata[link_pkg::C_SYNCPOL] = st_q.sync_polarity_sel;
                st_d.rdata[link_pkg::C_FRAME]   = st_q.frame_en;
                st_d.rdata[link_pkg::C_BYPASS]  = st_q.bypass;
                st_d.rdata[link_pkg::C_REFRAME] = st_q.await;
              end
              link_pkg::STAT_OFS: begin
                st_d.rdata[link_pkg::S_LINK]  = st_q.link;
                st_d.rdata[link_pkg::S_SYNC]  = st_q.sync;
                st_d.rdata[link_pkg::S_PORTA] = port_a;
                st_d.rdata[link_pkg::S_TXOFF] = tx_output_off;
                st_d.rdata[link_pkg::S_EMPTY] = !fifo_out_valid;
                st_d.rdata[link_pkg::S_FULL]  = !fifo_in_ready;
                st_d.rdata[link_pkg::S_OVF]   = st_q.ovf;
              end
              link_pkg::DATA_OFS: begin
                st_d.rdata[link_pkg::D_VALID] = fifo_out_valid;
                st_d.rdata[9:0]               = fifo_out_data;
              end
              default: begin
                st_d.rdata = '0;
              end
            endcase
          end
        end
      end
      link_pkg::BUS_ACK: begin
        st_d.bus  = link_pkg::BUS_IDLE;
        st_d.wreq = 1'b1;
      end
      default: begin
        st_d.bus  = link_pkg::BUS_IDLE;
        st_d.wreq = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q          <= '0;
      st_q.bus      <= link_pkg::BUS_IDLE;
      st_q.wreq     <= 1'b1;
      st_q.frame_en <= link_pkg::FRAME_RST;
      // reset leaves the transmitter in its off pattern
      st_q.tx_p     <= 1'b1;
      st_q.port_sw  <= link_pkg::BIT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // received characters
  // ****************************************
  // the bus drains the fifo; a full fifo drops and flags the character
  char_fifo #(
    .WIDTH(link_pkg::CHAR_W),
    .DEPTH(link_pkg::FIFO_DEPTH)
  ) rx_fifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .in_valid (char_done),
    .in_data  (char_word),
    .in_ready (fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data (fifo_out_data),
    .out_ready(fifo_pop)
  );

  // character clock without short pulses
  char_clock_gen #(
    .HALF(5)
  ) rx_clock (
    .clk      (clk),
    .rst_b    (rst_b),
    .want_high(want_high),
    .char_clk (recovered_char_clock)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence hold_high_s;
    recovered_char_clock [*4];
  endsequence

  sequence hold_low_s;
    !recovered_char_clock [*4];
  endsequence

  // transmitter
  tx_off_pins_a: assert property (tx_output_off |=> tx_serial_pos && !tx_serial_neg)
    else $error("tx off did not force pins");
  tx_follow_a: assert property (rst_b && !tx_output_off |=>
    tx_serial_pos == $past(st_q.tx_sr[9]) && tx_serial_neg != tx_serial_pos)
    else $error("tx pins do not follow data");
  txoff_strap_a: assert property (strap_txoff_conn && link_control |=> tx_serial_pos && !tx_serial_neg)
    else $error("connector off not obeyed");

  // port selection and status
  port_loop_a: assert property (!strap_port_conn && !st_q.port_sw |-> rx_bit == st_q.tx_sr[9])
    else $error("loopback port not selected");
  port_conn_a: assert property (strap_port_conn |-> port_a == loopback_ctrl)
    else $error("connector port select ignored");
  detect_pol_a: assert property (port_a && optical_detect && !st_q.detect_polarity_sel |=> link_status)
    else $error("link status polarity wrong");
  link_pol_hi_a: assert property (sig_present && st_q.detect_polarity_sel |=> !link_status)
    else $error("inverted link status wrong");

  // sync flag and framing
  bypass_sync_a: assert property (char_done && k28_hit && st_q.bypass ##1 st_q.bypass |=>
    sync_char_flag == $past(st_q.sync_polarity_sel))
    else $error("bypass sync flag wrong");
  await_sync_a: assert property (st_q.await && !st_q.bypass |=> sync_char_flag == !$past(st_q.sync_polarity_sel))
    else $error("sync flag not held while awaiting");
  decode_sync_a: assert property (char_done && k28_hit && !st_q.bypass ##1 !st_q.bypass |=>
    sync_char_flag == !$past(st_q.sync_polarity_sel))
    else $error("decode sync flag wrong");
  reframe_arm_a: assert property (wr_ctrl && writedata[link_pkg::C_REFRAME] |=> st_q.await)
    else $error("reframe not armed");
  frame_bound_a: assert property (st_q.frame_en && k28_hit |=> st_q.rx_cnt == 4'h0)
    else $error("sync did not set boundary");
  frame_off_a: assert property (!st_q.frame_en && st_q.rx_cnt != link_pkg::LAST_BIT |=>
    st_q.rx_cnt == $past(st_q.rx_cnt) + 4'h1)
    else $error("boundary moved while framing off");

  // character clock, data and bus
  clk_high_a: assert property ($rose(recovered_char_clock) |-> hold_high_s)
    else $error("short high pulse on char clock");
  clk_low_a: assert property ($fell(recovered_char_clock) |-> hold_low_s)
    else $error("short low pulse on char clock");
  decode_width_a: assert property (char_done && !st_q.bypass |=> rx_data[9:8] == 2'b00)
    else $error("decode output wider than eight bits");
  bus_answer_a: assert property ((read || write) && waitrequest && st_q.bus == link_pkg::BUS_IDLE |=>
    !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");
  ovf_set_a: assert property (char_done && !fifo_in_ready |=> st_q.ovf)
    else $error("overflow not flagged");
  pop_match_a: assert property (fifo_pop |-> st_q.rdata[9:0] == fifo_out_data)
    else $error("popped word differs from answer");
endmodule

// ### tb/optical_partner.sv
/*
  Model of the optical module at the receiver A port: sends a looping
  sync character stream, MSB first, one bit per clock.
  Assumes the bench raises sending and slip just after a clock edge.
*/
`timescale 1ns/1ps
module optical_partner (
  // clock
  input  wire logic clk,
  // bench controls
  input  wire logic sending,
  input  wire logic slip,
  // serial side
  output logic      serial_in_optical,
  output logic      optical_detect
);
  logic [3:0] bit_q;
  logic       rd_q;
  logic [9:0] ch;

  // alternate running disparity so the stream stays dc balanced
  assign ch = rd_q ? link_pkg::K28_RDP : link_pkg::K28_RDN;

  initial begin
    bit_q = 4'h0;
    rd_q = 1'b0;
    serial_in_optical = 1'b0;
    optical_detect = 1'b0;
  end

  // an idle line toggles so no stale bit is ever seen; slip repeats a bit to move the boundary
  always @(posedge clk) begin
    optical_detect <= sending;
    if (!sending) begin
      serial_in_optical <= ~serial_in_optical;
    end else begin
      serial_in_optical <= ch[link_pkg::LAST_BIT - bit_q];
      if (!slip && bit_q == link_pkg::LAST_BIT) begin
        bit_q <= 4'h0;
        rd_q <= ~rd_q;
      end else if (!slip) begin
        bit_q <= bit_q + 4'h1;
      end
    end
  end
endmodule

// ### tb/serial_link_ctrl_tb.sv
/*
  Self-checking bench for the serial link port and framing control.
  Assumes the register map of link_pkg and one 40 MHz clock.
*/
`timescale 1ns/1ps
module serial_link_ctrl_tb;
  // ****************************************
  // signals and design
  // ****************************************
  logic        clk, rst_b, read, write, waitrequest;
  logic [3:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic        strap_port_conn, strap_txoff_conn, loopback_ctrl, link_control;
  logic        serial_in_optical, optical_detect, tx_serial_pos, tx_serial_neg;
  logic        link_status, sync_char_flag, recovered_char_clock, prev_cc, clk_seen;
  logic [9:0]  rx_data;
  logic        sending, slip;
  int          bad_count, total_checks, run_len;

  serial_link_ctrl dut (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .waitrequest(waitrequest), .readdata(readdata),
    .strap_port_conn(strap_port_conn), .strap_txoff_conn(strap_txoff_conn),
    .loopback_ctrl(loopback_ctrl), .link_control(link_control),
    .serial_in_optical(serial_in_optical), .optical_detect(optical_detect),
    .tx_serial_pos(tx_serial_pos), .tx_serial_neg(tx_serial_neg), .link_status(link_status),
    .sync_char_flag(sync_char_flag), .recovered_char_clock(recovered_char_clock), .rx_data(rx_data)
  );

  optical_partner far_end (
    .clk(clk), .sending(sending), .slip(slip),
    .serial_in_optical(serial_in_optical), .optical_detect(optical_detect)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // request held until waitrequest is sampled low; read data taken at that edge
  task automatic bus_access(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 16);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (waitrequest !== 1'b0) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  // let characters from before a change pass, then a bounded look for a 0x?05 character
  task automatic wait_char(output logic found);
    found = 1'b0;
    repeat (20) @(posedge clk);
    for (int i = 0; i < 60 && !found; i++) begin
      @(posedge clk);
      found = (rx_data[7:0] === 8'h05);
    end
  endtask

  // counts of high samples on both tx pins over one full 20-bit sync period
  task automatic tx_count(output logic [31:0] c);
    c = 32'h0;
    repeat (3) @(posedge clk);
    repeat (20) begin
      @(posedge clk);
      c[31:16] += {15'h0, tx_serial_pos === 1'b1};
      c[15:0] += {15'h0, tx_serial_neg === 1'b1};
    end
  endtask

  task automatic probe_port(input logic [31:0] exp);
    repeat (3) @(posedge clk);
    bus_access(1'b0, link_pkg::STAT_OFS, 32'h0);
    check_word({30'h0, link_status, rd[link_pkg::S_PORTA]}, exp);
  endtask

  // phase length watch on the character clock; the first phase after reset is partial
  always @(posedge clk) begin
    if (!rst_b) begin
      run_len = 0;
      clk_seen = 1'b0;
    end else if (recovered_char_clock === prev_cc) begin
      run_len++;
    end else begin
      if (clk_seen) check_word({31'h0, run_len >= 5}, 32'h1);
      clk_seen = 1'b1;
      run_len = 1;
    end
    prev_cc = recovered_char_clock;
  end

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset;
    bus_access(1'b0, link_pkg::CTRL_OFS, 32'h0);
    check_word(rd, 32'h10);
    bus_access(1'b1, 4'hc, 32'hffffffff);
    bus_access(1'b0, 4'hc, 32'h0);
    check_word(rd, 32'h0);
    bus_access(1'b0, link_pkg::CTRL_OFS, 32'h0);
    check_word(rd, 32'h10);
    $display("test_reset done");
  endtask

  // loopback characters fill the fifo unread, then it is drained faster than it fills
  task automatic test_fifo;
    logic [31:0] last;
    int n;
    last = 32'h0;
    n = 0;
    repeat (200) @(posedge clk);
    bus_access(1'b0, link_pkg::STAT_OFS, 32'h0);
    check_word({29'h0, rd[6:4]}, 32'h6);
    do begin
      bus_access(1'b0, link_pkg::DATA_OFS, 32'h0);
      n++;
      if (rd[31] === 1'b1) last = rd;
    end while (rd[31] === 1'b1 && n < 40);
    check_word({31'h0, n > 16 && n < 40}, 32'h1);
    check_word({31'h0, last[9:0] === 10'h0fa || last[9:0] === 10'h005}, 32'h1);
    bus_access(1'b1, link_pkg::STAT_OFS, 32'h40);
    bus_access(1'b0, link_pkg::STAT_OFS, 32'h0);
    check_word({31'h0, rd[6]}, 32'h0);
    $display("test_fifo done");
  endtask

  task automatic test_txoff;
    logic [31:0] c;
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h12);
    tx_count(c);
    check_word(c, 32'h00140000);
    bus_access(1'b0, link_pkg::STAT_OFS, 32'h0);
    check_word({31'h0, rd[link_pkg::S_TXOFF]}, 32'h1);
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h10);
    tx_count(c);
    check_word(c, 32'h000a000a);
    strap_txoff_conn <= 1'b1;
    link_control <= 1'b1;
    tx_count(c);
    check_word(c, 32'h00140000);
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h12);
    link_control <= 1'b0;
    tx_count(c);
    check_word(c, 32'h000a000a);
    strap_txoff_conn <= 1'b0;
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h10);
    $display("test_txoff done");
  endtask

  // optical module silent: loopback counts as a signal, the optical port does not
  task automatic test_detect;
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h14);
    probe_port(32'h0);
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h10);
    probe_port(32'h2);
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h11);
    probe_port(32'h1);
    strap_port_conn <= 1'b1;
    loopback_ctrl <= 1'b0;
    probe_port(32'h2);
    loopback_ctrl <= 1'b1;
    probe_port(32'h1);
    strap_port_conn <= 1'b0;
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h10);
    $display("test_detect done");
  endtask

  task automatic test_sync;
    logic found;
    logic [31:0] exp;
    for (int m = 0; m < 4; m++) begin
      bus_access(1'b1, link_pkg::CTRL_OFS, {26'h0, m[1], 1'b1, m[0], 3'h0});
      wait_char(found);
      repeat (2) @(posedge clk);
      exp = {20'h0, m[1] ? m[0] : ~m[0], 1'b1, m[1] ? 10'h305 : 10'h005};
      check_word({20'h0, sync_char_flag, found, rx_data}, exp);
    end
    $display("test_sync done");
  endtask

  // optical stream: lock, slip with framing off, relock, then reframe while idle
  task automatic test_framing;
    logic found;
    sending <= 1'b1;
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h39);
    wait_char(found);
    check_word({31'h0, found}, 32'h1);
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h29);
    slip <= 1'b1;
    repeat (3) @(posedge clk);
    slip <= 1'b0;
    wait_char(found);
    check_word({30'h0, found, sync_char_flag}, 32'h0);
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h39);
    wait_char(found);
    check_word({30'h0, found, clk_seen}, 32'h3);
    sending <= 1'b0;
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h11);
    repeat (30) @(posedge clk);
    check_word({31'h0, sync_char_flag}, 32'h0);
    bus_access(1'b1, link_pkg::CTRL_OFS, 32'h51);
    repeat (5) @(posedge clk);
    bus_access(1'b0, link_pkg::CTRL_OFS, 32'h0);
    check_word({30'h0, rd[link_pkg::C_REFRAME], sync_char_flag}, 32'h3);
    sending <= 1'b1;
    repeat (60) @(posedge clk);
    bus_access(1'b0, link_pkg::CTRL_OFS, 32'h0);
    check_word({31'h0, rd[link_pkg::C_REFRAME]}, 32'h0);
    $display("test_framing done");
  endtask

  // ****************************************
  // clock, reset and sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {rst_b, read, write, address, writedata} = '0;
    {strap_port_conn, strap_txoff_conn, loopback_ctrl, link_control, sending, slip} = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    check_word({30'h0, tx_serial_pos, tx_serial_neg}, 32'h2);
    rst_b <= 1'b1;
    test_reset();
    test_fifo();
    test_txoff();
    test_detect();
    test_sync();
    test_framing();
    tally_and_finish();
  end
endmodule
